/* src/cdcsp_pkg.sv */
// Constants and types for the codec serial port and clocking block
// Functional notes
// - Internal master clock runs at 256 times the sample rate, 128 times with low group delay.
// - Three cascaded dividers: first two by 1/2/3, third by 1/2/4.
// - At 48 kHz, ADC modulator ticks at INTERNAL_MASTER_CLOCK/4, DAC modulator at INTERNAL_MASTER_CLOCK/2.
// - Reset returns registers to defaults and purges held sample data.
// - Reset process lasts 3072 master clock periods; no programming meanwhile.
// - Serial data in sampled after reset: high selects slave, low master.
// - Seven 10-bit control registers via 16-bit words; peak register read-only.
// - Control word has read/write flag, address, data; reads ignore data.
// - Control registers are written only through the serial port; Wishbone can only read them.
// - Mixed mode uses separate control and data slots, each with frame sync.
// - After reset the port starts in mixed control-and-audio mode.
// - Data mode has one frame sync per sample and no control slot.
// - After entering data mode, control changes are ignored until reset.
// - Audio words are 16, 20 or 24 bits, defaulting to 16.
// - In master operation the device drives frame sync and bit clock.
// - A control bit switches the on-chip voltage reference on; it is off after reset.
// - Word layout: flag bit 15, address 14-11, zero bit 10, data 9-0.
// - Read data returns at the next sample interval.
// - Low group delay makes the sample rate INTERNAL_MASTER_CLOCK/128.
package cdcsp_pkg;
  localparam int NUM_CREG = 7;
  localparam int CREG_W = 10;
  localparam int CR_A = 0;
  localparam int CR_B = 1;
  localparam int CR_C = 2;
  localparam int CR_D = 3;
  localparam int CR_E = 4;
  localparam int CR_F = 5;
  localparam int CR_G = 6;
  localparam logic [NUM_CREG-1:0][CREG_W-1:0] CREG_RESET = {10'h000, 10'h000, 10'h000,
    10'h008, 10'h000, 10'h000, 10'h000};
  localparam int CRA_REF_BIT = 3;
  localparam int CRC_LGD_BIT = 1;
  localparam int CRC_WL_LSB = 4;
  localparam int CRD_MASTER_BIT = 0;
  localparam int CRD_MIXED_BIT = 3;
  localparam int CRE_PEAK_BIT = 5;
  localparam int PEAK_W = 6;
  localparam int NUM_PRE = 3;
  localparam int PRE_LSB = 0;
  localparam int PRE_W = 2;
  localparam logic [11:0] RESET_LAST = 12'hBFF;
  localparam logic [7:0] SAMPLE_LAST = 8'hFF;
  localparam logic [7:0] SAMPLE_LAST_LGD = 8'h7F;
  localparam logic [1:0] ADC_MOD_LAST = 2'h3;
  localparam logic DAC_MOD_LAST = 1'b1;
  localparam logic [6:0] POS_LAST = 7'h7F;
  localparam logic [6:0] POS_LAST_LGD = 7'h3F;
  localparam logic [6:0] POS_MID_PRE = 7'h3F;
  localparam logic [6:0] POS_MID_PRE_LGD = 7'h1F;
  localparam int AUDIO_W = 24;
  localparam int CTRL_W = 16;
  localparam logic [4:0] LEN_CTRL = 5'h10;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [7:0] WB_STATUS = 8'h00;
  localparam logic [7:0] WB_TXAUDIO = 8'h04;
  localparam logic [7:0] WB_RXAUDIO = 8'h08;
  localparam logic [7:0] WB_CREG_BASE = 8'h40;
  localparam int STAT_BUSY = 0;
  localparam int STAT_MASTER = 1;
  localparam int STAT_DATAMODE = 2;

  typedef struct packed {
    logic rw;
    logic [3:0] addr;
    logic rsvd;
    logic [CREG_W-1:0] data;
  } cdcsp_ctrl_word_t;

  typedef struct packed {
    logic internal_master_clock;
    logic sample;
    logic adcMod;
    logic dacMod;
  } cdcsp_ticks_t;

  typedef enum logic [1:0] {ST_RESET = 2'b01, ST_RUN = 2'b10} cdcsp_state_t;

  // Last count of a divider stage; the third stage offers four instead of three
  function automatic logic [1:0] divLast(input logic [1:0] code, input logic third);
    unique case (code)
      2'h1: divLast = 2'h1;
      2'h2: divLast = third ? 2'h3 : 2'h2;
      default: divLast = 2'h0;
    endcase
  endfunction : divLast
endpackage : cdcsp_pkg

/* src/cdcsp_top.sv */
// Codec serial port, master clock prescalers and reset sequence
`timescale 1ns/1ps
module cdcsp_top (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic clkEn, // Freezes all state while low
  input wire logic mclkIn, // External master clock level
  input wire logic dinIn, // Serial data into the device
  output logic doutOut, // Serial data out of the device
  input wire logic fsIn, // Frame sync pin level
  output logic fsOut, // Frame sync driven level
  output logic fsOe_b, // Frame sync enable, low while driving
  input wire logic sclkIn, // Serial bit clock pin level
  output logic sclkOut, // Serial bit clock driven level
  output logic sclkOe_b, // Bit clock enable, low while driving
  input wire logic [5:0] peakIn, // ADC peak level from converter
  output logic refEnable, // On-chip reference enable
  output cdcsp_pkg::cdcsp_ticks_t ticks, // Clock tick pulses
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);
  cdcsp_pkg::cdcsp_state_t stateReg;
  logic busy;
  logic resetDone;
  logic [11:0] mclkCnt;
  logic mclkPrev;
  logic mclkRise;
  logic [cdcsp_pkg::CREG_W-1:0] cregs [cdcsp_pkg::NUM_CREG];
  logic masterMode;
  logic mixedMode;
  logic dataMode;
  logic lgd;
  logic [cdcsp_pkg::NUM_PRE:0] stageTick;
  logic [1:0] stageCnt [cdcsp_pkg::NUM_PRE];
  logic [1:0] stageLast [cdcsp_pkg::NUM_PRE];
  logic imTick;
  logic [7:0] imCnt;
  logic [7:0] sampleLast;
  logic sampleTick;
  logic sclkReg;
  logic fsReg;
  logic [6:0] bitPos;
  logic [6:0] posNext;
  logic [6:0] posLast;
  logic [6:0] posMid;
  logic sclkPrev;
  logic sclkNow;
  logic fsNow;
  logic bitRise;
  logic bitFall;
  logic armed;
  logic active;
  logic isCtrl;
  logic slotPhase;
  logic [4:0] bitCnt;
  logic [4:0] frameLen;
  logic [4:0] wordLen;
  logic [cdcsp_pkg::AUDIO_W-1:0] txShift;
  logic [cdcsp_pkg::AUDIO_W-1:0] rxShift;
  logic [cdcsp_pkg::AUDIO_W-1:0] rxWord;
  logic frameDone;
  logic ctrlLoad;
  cdcsp_pkg::cdcsp_ctrl_word_t cw;
  logic cwWrite;
  logic readPend;
  logic [3:0] readAddr;
  cdcsp_pkg::cdcsp_ctrl_word_t replyWord;
  logic peakClear;
  logic [5:0] peakBase;
  logic [cdcsp_pkg::AUDIO_W-1:0] txAudioReg;
  logic [cdcsp_pkg::AUDIO_W-1:0] rxAudioReg;
  logic ackReg;
  logic wbReq;
  logic wbWrite;
  logic [31:0] rdData;

  assign busy = (stateReg == cdcsp_pkg::ST_RESET);
  assign mclkRise = mclkIn & ~mclkPrev;
  assign resetDone = busy & mclkRise & (mclkCnt == cdcsp_pkg::RESET_LAST);
  assign masterMode = cregs[cdcsp_pkg::CR_D][cdcsp_pkg::CRD_MASTER_BIT];
  assign mixedMode = cregs[cdcsp_pkg::CR_D][cdcsp_pkg::CRD_MIXED_BIT];
  assign dataMode = ~mixedMode;
  assign lgd = cregs[cdcsp_pkg::CR_C][cdcsp_pkg::CRC_LGD_BIT];
  assign refEnable = cregs[cdcsp_pkg::CR_A][cdcsp_pkg::CRA_REF_BIT];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      mclkPrev <= 1'b0;
    else if (clkEn)
      mclkPrev <= mclkIn;
  end

  // Reset process counts master clock periods before the port comes alive
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateReg <= cdcsp_pkg::ST_RESET;
      mclkCnt <= 12'h000;
    end
    else if (clkEn)
    begin
      unique case (stateReg)
        cdcsp_pkg::ST_RESET:
        begin
          if (resetDone)
            stateReg <= cdcsp_pkg::ST_RUN;
          else if (mclkRise)
            mclkCnt <= mclkCnt + 12'h001;
        end
        cdcsp_pkg::ST_RUN:
          stateReg <= cdcsp_pkg::ST_RUN;
        default:
          stateReg <= cdcsp_pkg::ST_RESET;
      endcase
    end
  end

  // Cascaded prescalers; each stage passes every Nth tick of the one before
  assign stageTick[0] = mclkRise & ~busy;
  for (genvar g = 0; g < cdcsp_pkg::NUM_PRE; g++)
  begin : g_pre
    assign stageLast[g] = cdcsp_pkg::divLast(
      cregs[cdcsp_pkg::CR_B][cdcsp_pkg::PRE_LSB + cdcsp_pkg::PRE_W*g +: cdcsp_pkg::PRE_W],
      g == cdcsp_pkg::NUM_PRE - 1);
    assign stageTick[g+1] = stageTick[g] & (stageCnt[g] >= stageLast[g]);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
      if (!rst_b)
        stageCnt[g] <= 2'h0;
      else if (clkEn && stageTick[g])
        stageCnt[g] <= (stageCnt[g] >= stageLast[g]) ? 2'h0 : stageCnt[g] + 2'h1;
    end
  end
  assign imTick = stageTick[cdcsp_pkg::NUM_PRE];

  // Sample interval from the internal master clock
  assign sampleLast = lgd ? cdcsp_pkg::SAMPLE_LAST_LGD : cdcsp_pkg::SAMPLE_LAST;
  assign sampleTick = imTick & (imCnt >= sampleLast);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      imCnt <= 8'h00;
      ticks <= '0;
    end
    else if (clkEn)
    begin
      if (imTick)
        imCnt <= sampleTick ? 8'h00 : imCnt + 8'h01;
      ticks.internal_master_clock <= imTick;
      ticks.sample <= sampleTick;
      ticks.adcMod <= imTick & (imCnt[1:0] == cdcsp_pkg::ADC_MOD_LAST);
      ticks.dacMod <= imTick & (imCnt[0] == cdcsp_pkg::DAC_MOD_LAST);
    end
  end

  // Master bit clock and frame sync; sync marks the bit before each slot
  assign posLast = lgd ? cdcsp_pkg::POS_LAST_LGD : cdcsp_pkg::POS_LAST;
  assign posMid = lgd ? cdcsp_pkg::POS_MID_PRE_LGD : cdcsp_pkg::POS_MID_PRE;
  assign posNext = (bitPos >= posLast) ? 7'h00 : bitPos + 7'h01;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkReg <= 1'b0;
      fsReg <= 1'b0;
      bitPos <= 7'h00;
    end
    else if (clkEn)
    begin
      if (busy || !masterMode)
      begin
        sclkReg <= 1'b0;
        fsReg <= 1'b0;
        bitPos <= 7'h00;
      end
      else if (imTick)
      begin
        sclkReg <= ~sclkReg;
        if (sclkReg)
        begin
          bitPos <= posNext;
          fsReg <= (posNext == posLast) | (mixedMode & (posNext == posMid));
        end
      end
    end
  end

  assign sclkOut = sclkReg;
  assign fsOut = fsReg;
  assign sclkOe_b = ~(masterMode & ~busy);
  assign fsOe_b = ~(masterMode & ~busy);
  assign sclkNow = masterMode ? sclkReg : sclkIn;
  assign fsNow = masterMode ? fsReg : fsIn;
  assign bitRise = sclkNow & ~sclkPrev & ~busy;
  assign bitFall = ~sclkNow & sclkPrev & ~busy;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sclkPrev <= 1'b0;
    else if (clkEn)
      sclkPrev <= sclkNow;
  end

  // Frame engine: sync at a rising edge, first bit out at the next fall
  always_comb
  begin
    unique case (cregs[cdcsp_pkg::CR_C][cdcsp_pkg::CRC_WL_LSB +: 2])
      cdcsp_pkg::WL_20: wordLen = cdcsp_pkg::LEN_20;
      cdcsp_pkg::WL_24: wordLen = cdcsp_pkg::LEN_24;
      default: wordLen = cdcsp_pkg::LEN_16;
    endcase
  end
  assign frameLen = isCtrl ? cdcsp_pkg::LEN_CTRL : wordLen;
  assign rxWord = {rxShift[cdcsp_pkg::AUDIO_W-2:0], dinIn};
  assign frameDone = bitRise & active & (bitCnt == frameLen - 5'h01);
  assign ctrlLoad = bitFall & armed & isCtrl;
  assign doutOut = txShift[cdcsp_pkg::AUDIO_W-1];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      armed <= 1'b0;
      active <= 1'b0;
      isCtrl <= 1'b0;
      slotPhase <= 1'b0;
      bitCnt <= 5'h00;
      txShift <= '0;
      rxShift <= '0;
      rxAudioReg <= '0;
    end
    else if (clkEn)
    begin
      if (busy)
      begin
        armed <= 1'b0;
        active <= 1'b0;
        slotPhase <= 1'b0;
        txShift <= '0;
        rxShift <= '0;
        rxAudioReg <= '0;
      end
      else if (bitRise)
      begin
        if (fsNow)
        begin
          armed <= 1'b1;
          isCtrl <= mixedMode & ~slotPhase;
          slotPhase <= mixedMode & ~slotPhase;
        end
        if (active)
        begin
          rxShift <= rxWord;
          bitCnt <= bitCnt + 5'h01;
        end
        if (frameDone)
        begin
          active <= 1'b0;
          txShift <= '0;
          if (!isCtrl)
            rxAudioReg <= rxWord << (5'(cdcsp_pkg::AUDIO_W) - frameLen);
        end
      end
      else if (bitFall)
      begin
        if (armed)
        begin
          armed <= 1'b0;
          active <= 1'b1;
          bitCnt <= 5'h00;
          rxShift <= '0;
          txShift <= isCtrl ? {replyWord, 8'h00} : txAudioReg;
        end
        else if (active)
          txShift <= txShift << 1;
      end
    end
  end

  // Control words: writes land at once, reads answer at the next sample
  assign cw = cdcsp_pkg::cdcsp_ctrl_word_t'(rxWord[cdcsp_pkg::CTRL_W-1:0]);
  assign cwWrite = frameDone & isCtrl & cw.rw & mixedMode
    & (cw.addr < 4'(cdcsp_pkg::NUM_CREG)) & (cw.addr != 4'(cdcsp_pkg::CR_F));
  assign peakClear = clkEn & readPend & sampleTick & (readAddr == 4'(cdcsp_pkg::CR_F));
  assign peakBase = peakClear ? 6'h00 : cregs[cdcsp_pkg::CR_F][cdcsp_pkg::PEAK_W-1:0];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readPend <= 1'b0;
      readAddr <= 4'h0;
      replyWord <= '0;
    end
    else if (clkEn)
    begin
      if (busy)
      begin
        readPend <= 1'b0;
        replyWord <= '0;
      end
      else
      begin
        if (frameDone && isCtrl && !cw.rw)
        begin
          readPend <= 1'b1;
          readAddr <= cw.addr;
        end
        else if (readPend && sampleTick)
          readPend <= 1'b0;
        if (readPend && sampleTick)
        begin
          replyWord.rw <= 1'b0;
          replyWord.addr <= readAddr;
          replyWord.rsvd <= 1'b0;
          replyWord.data <= (readAddr < 4'(cdcsp_pkg::NUM_CREG)) ? cregs[readAddr[2:0]] : '0;
        end
        else if (ctrlLoad)
          replyWord <= '0;
      end
    end
  end

  // Control registers; defaults return during reset and mode strap at its end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < cdcsp_pkg::NUM_CREG; i++)
        cregs[i] <= cdcsp_pkg::CREG_RESET[i];
    end
    else if (clkEn)
    begin
      if (resetDone)
        cregs[cdcsp_pkg::CR_D][cdcsp_pkg::CRD_MASTER_BIT] <= ~dinIn;
      else if (cwWrite)
        cregs[cw.addr[2:0]] <= cw.data;
      if (cregs[cdcsp_pkg::CR_E][cdcsp_pkg::CRE_PEAK_BIT] && peakIn > peakBase)
        cregs[cdcsp_pkg::CR_F][cdcsp_pkg::PEAK_W-1:0] <= peakIn;
      else
        cregs[cdcsp_pkg::CR_F][cdcsp_pkg::PEAK_W-1:0] <= peakBase;
    end
  end

  // Wishbone slave: audio words and status, control registers read-only mirror
  assign wbReq = wb_cyc_i & wb_stb_i;
  assign wbWrite = wbReq & ackReg & wb_we_i & (wb_adr_i == cdcsp_pkg::WB_TXAUDIO);
  assign wb_ack_o = ackReg;

  always_comb
  begin
    rdData = 32'h0000_0000;
    if (wb_adr_i == cdcsp_pkg::WB_STATUS)
    begin
      rdData[cdcsp_pkg::STAT_BUSY] = busy;
      rdData[cdcsp_pkg::STAT_MASTER] = masterMode;
      rdData[cdcsp_pkg::STAT_DATAMODE] = dataMode;
    end
    else if (wb_adr_i == cdcsp_pkg::WB_TXAUDIO)
      rdData[cdcsp_pkg::AUDIO_W-1:0] = txAudioReg;
    else if (wb_adr_i == cdcsp_pkg::WB_RXAUDIO)
      rdData[cdcsp_pkg::AUDIO_W-1:0] = rxAudioReg;
    else if (wb_adr_i[7:5] == cdcsp_pkg::WB_CREG_BASE[7:5] && wb_adr_i[1:0] == 2'h0
             && wb_adr_i[4:2] < 3'(cdcsp_pkg::NUM_CREG))
      rdData[cdcsp_pkg::CREG_W-1:0] = cregs[wb_adr_i[4:2]];
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ackReg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ackReg <= wbReq & ~ackReg;
      if (wbReq && !ackReg)
        wb_dat_o <= rdData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      txAudioReg <= '0;
    else if (clkEn)
    begin
      if (busy)
        txAudioReg <= '0;
      else if (wbWrite)
      begin
        for (int b = 0; b < cdcsp_pkg::AUDIO_W/8; b++)
          if (wb_sel_i[b])
            txAudioReg[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_readDue;
    clkEn && readPend && sampleTick;
  endsequence
  property p_readReply;
    s_readDue |=> !readPend && replyWord.addr == $past(readAddr) && !replyWord.rw;
  endproperty
  a_readReply: assert property (p_readReply) else $error("read reply not loaded");
  property p_resetLen;
    clkEn && $past(clkEn) && $fell(busy) |-> $past(mclkCnt) == cdcsp_pkg::RESET_LAST;
  endproperty
  a_resetLen: assert property (p_resetLen) else $error("reset length wrong");
  property p_quietInReset;
    busy |-> !active && !armed && sclkOe_b && fsOe_b;
  endproperty
  a_quietInReset: assert property (p_quietInReset) else $error("port active in reset");
  property p_strap;
    clkEn && resetDone |=> masterMode == !$past(dinIn) && mixedMode;
  endproperty
  a_strap: assert property (p_strap) else $error("mode strap wrong");
  property p_sampleRate;
    sampleTick |-> imTick && imCnt == (lgd ? cdcsp_pkg::SAMPLE_LAST_LGD : cdcsp_pkg::SAMPLE_LAST);
  endproperty
  a_sampleRate: assert property (p_sampleRate) else $error("sample tick misplaced");
  property p_modTicks;
    ticks.adcMod |-> ticks.dacMod && ticks.internal_master_clock;
  endproperty
  a_modTicks: assert property (p_modTicks) else $error("modulator ticks out of step");
  property p_cascade;
    stageTick[3] |-> stageTick[2] && stageTick[1] && stageTick[0];
  endproperty
  a_cascade: assert property (p_cascade) else $error("prescaler cascade broken");
  property p_dataLock;
    clkEn && !busy && dataMode |=> dataMode && $stable(cregs[cdcsp_pkg::CR_C]);
  endproperty
  a_dataLock: assert property (p_dataLock) else $error("registers changed in data mode");
  property p_noWriteF;
    cwWrite |-> cw.addr != 4'(cdcsp_pkg::CR_F) && mixedMode;
  endproperty
  a_noWriteF: assert property (p_noWriteF) else $error("illegal control write");
  property p_masterDrive;
    !busy && masterMode |-> !sclkOe_b && !fsOe_b;
  endproperty
  a_masterDrive: assert property (p_masterDrive) else $error("master not driving");
  property p_ackPulse;
    ackReg |=> !ackReg;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than a cycle");
endmodule : cdcsp_top

/* tb/cdcsp_dsp_model.sv */
// Behavioural controller serial port that faces the codec in master operation
`timescale 1ns/1ps
module cdcsp_dsp_model (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic strap, // Level held on the data line at reset
  input wire logic hold, // Keep the strap level on the data line
  input wire logic sclk, // Bit clock pin level
  input wire logic fs, // Frame sync pin level
  input wire logic dout, // Serial data from the device
  input wire logic [15:0] txWord, // Control word to send
  input wire logic txReq, // Queue txWord for the next control slot
  output logic mclk, // External master clock
  output logic din, // Serial data to the device
  output logic txDone, // Pulse when a queued word has gone out
  output logic [15:0] rxWord // Last word heard in any slot
);
  logic [1:0] div = 2'h0;
  logic sclkPrev, active, ctrlNext, pending, sending;
  logic [4:0] cnt;
  logic [15:0] sh, rx;
  // Free running, a quarter of the system clock
  always @(posedge clk_sys) div <= div + 2'h1;
  assign mclk = div[1];
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkPrev <= 1'b0;
      active <= 1'b0;
      ctrlNext <= 1'b1;
      pending <= 1'b0;
      sending <= 1'b0;
      txDone <= 1'b0;
      cnt <= 5'h00;
      sh <= 16'h0000;
      rx <= 16'h0000;
      rxWord <= 16'h0000;
      din <= strap;
    end
    else
    begin
      sclkPrev <= sclk;
      txDone <= 1'b0;
      if (txReq)
        pending <= 1'b1;
      if (sclk && !sclkPrev && fs && !active)
      begin
        // Slots alternate, control first after reset
        active <= 1'b1;
        cnt <= 5'h00;
        ctrlNext <= !ctrlNext;
        sending <= ctrlNext && pending;
        if (ctrlNext && pending)
          pending <= 1'b0;
        sh <= txWord;
      end
      else if (sclk && !sclkPrev && active)
      begin
        rx <= {rx[14:0], dout};
        cnt <= cnt + 5'h01;
        if (cnt == 5'h0F)
        begin
          active <= 1'b0;
          txDone <= sending;
          sending <= 1'b0;
          rxWord <= {rx[14:0], dout};
        end
      end
      else if (!sclk && sclkPrev)
      begin
        if (hold)
          din <= strap;
        else if (active && sending)
          din <= sh[15];
        else
          din <= !din;
        if (active && sending)
          sh <= {sh[14:0], 1'b0};
      end
    end
  end
endmodule : cdcsp_dsp_model

/* tb/cdcsp_top_test.sv */
// Self-checking bench for the codec serial port and clocking block
`timescale 1ns/1ps
module cdcsp_top_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h00000000;
  logic hold = 1'b1;
  logic strap = 1'b0;
  logic slvOn = 1'b0;
  logic [7:0] slvCnt = 8'h00;
  logic txReq = 1'b0;
  logic [15:0] txWord = 16'h0000;
  logic mclk, din, dout, fsOut, fsOe_b, sclkOut, sclkOe_b, refEnable, ack, txDone;
  logic [31:0] datO, rd;
  logic [15:0] rxWord;
  cdcsp_pkg::cdcsp_ticks_t ticks;
  // Controller clocks the port while the codec is a slave: 32-bit frames
  wire slvClk = slvOn && slvCnt[2];
  wire slvFs = slvOn && slvCnt[7:3] == 5'h1F;
  wire fsPin = fsOe_b ? slvFs : fsOut;
  wire sclkPin = sclkOe_b ? slvClk : sclkOut;
  int n_mismatch = 0;
  int cmp_count = 0;
  int mclkCount = 0;
  always #2 clk_sys = !clk_sys;
  always @(posedge mclk) if (rst_b) mclkCount++;
  always @(posedge clk_sys) if (slvOn) slvCnt <= slvCnt + 8'h01;
  cdcsp_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1), .mclkIn(mclk),
    .dinIn(din), .doutOut(dout), .fsIn(fsPin), .fsOut(fsOut), .fsOe_b(fsOe_b),
    .sclkIn(sclkPin), .sclkOut(sclkOut), .sclkOe_b(sclkOe_b), .peakIn(6'h15),
    .refEnable(refEnable), .ticks(ticks), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
    .wb_dat_o(datO), .wb_ack_o(ack));
  cdcsp_dsp_model u_dsp (.clk_sys(clk_sys), .rst_b(rst_b), .strap(strap), .hold(hold),
    .sclk(sclkPin), .fs(fsPin), .dout(dout), .txWord(txWord), .txReq(txReq),
    .mclk(mclk), .din(din), .txDone(txDone), .rxWord(rxWord));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (ack !== 1'b1) n_mismatch++;
    rd = datO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic ctl(input logic [15:0] w);
    int n;
    n = 0;
    txWord <= w;
    txReq <= 1'b1;
    @(posedge clk_sys);
    txReq <= 1'b0;
    while (txDone !== 1'b1 && n < 20000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (txDone !== 1'b1) n_mismatch++;
    repeat (4) @(posedge clk_sys);
  endtask : ctl
  // Counts ticks over one sample interval
  task automatic span(input int cyExp);
    int im, ad, da, cy;
    im = 0;
    ad = 0;
    da = 0;
    cy = 0;
    while (ticks.sample !== 1'b1 && cy < 30000)
    begin
      @(posedge clk_sys);
      cy++;
    end
    cy = 0;
    do
    begin
      @(posedge clk_sys);
      cy++;
      if (ticks.internal_master_clock === 1'b1) im++;
      if (ticks.adcMod === 1'b1) ad++;
      if (ticks.dacMod === 1'b1) da++;
    end while (ticks.sample !== 1'b1 && cy < 30000);
    chk(im, 256);
    chk(ad, 64);
    chk(da, 128);
    chk(cy, cyExp);
  endtask : span
  // Polls status until the reset process is over
  task automatic ready;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, cdcsp_pkg::WB_STATUS, 32'h0);
      n++;
    end while (rd[0] === 1'b1 && n < 6000);
    if (rd[0] !== 1'b0) n_mismatch++;
  endtask : ready
  task automatic t_reset;
    wb(1'b0, cdcsp_pkg::WB_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, cdcsp_pkg::WB_CREG_BASE + 8'(4 * i), 32'h0);
      chk(rd, (i == 3) ? 32'h00000008 : 32'h00000000);
    end
    wb(1'b1, 8'h40, 32'h000003FF);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
    ready;
    chk(32'(mclkCount >= 3072 && mclkCount <= 3074), 32'h1);
    hold <= 1'b0;
    $display("reset test done");
  endtask : t_reset
  task automatic t_run;
    int n;
    wb(1'b0, cdcsp_pkg::WB_STATUS, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 8'h4C, 32'h0);
    chk(rd, 32'h9);
    chk({fsOe_b, sclkOe_b}, 2'b00);
    span(1024);
    ctl(16'h8008);
    chk(refEnable, 1'b1);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h8);
    ctl(16'hA80F);
    wb(1'b0, 8'h54, 32'h0);
    chk(rd, 32'h0);
    ctl(16'hB2A5);
    ctl(16'h33FF);
    n = 0;
    while (rxWord[9:0] !== 10'h2A5 && n < 3100)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(rxWord, 16'h32A5);
    wb(1'b0, 8'h58, 32'h0);
    chk(rd, 32'h2A5);
    wb(1'b1, cdcsp_pkg::WB_TXAUDIO, 32'h00C3A500);
    n = 0;
    while (rxWord !== 16'hC3A5 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(rxWord, 16'hC3A5);
    $display("control test done");
  endtask : t_run
  task automatic t_modes;
    ctl(16'h8806);
    span(6144);
    ctl(16'h9801);
    wb(1'b0, cdcsp_pkg::WB_STATUS, 32'h0);
    chk(rd, 32'h6);
    ctl(16'h8000);
    chk(refEnable, 1'b1);
    $display("mode test done");
  endtask : t_modes
  task automatic t_slave;
    hold <= 1'b1;
    strap <= 1'b1;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk(refEnable, 1'b0);
    ready;
    hold <= 1'b0;
    chk(rd, 32'h0);
    wb(1'b0, 8'h4C, 32'h0);
    chk(rd, 32'h8);
    chk({fsOe_b, sclkOe_b}, 2'b11);
    slvOn <= 1'b1;
    ctl(16'h8008);
    chk(refEnable, 1'b1);
    $display("slave test done");
  endtask : t_slave
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    n_mismatch++;
    conclude;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_run;
    t_modes;
    t_slave;
    conclude;
  end
endmodule : cdcsp_top_test
